// [src/pbw_consts.svh]
`ifndef PBW_CONSTS_SVH
`define PBW_CONSTS_SVH

// ==========================================================================
// Peripheral register selectors on the 12-bit peripheral address
// ==========================================================================
`define PBW_ADDR_WDOG1_MODE       12'h0d0
`define PBW_ADDR_WDOG2_MODE       12'h0d1
`define PBW_ADDR_TIMER_A_CC0      12'h0a0
`define PBW_ADDR_TIMER_A_CC1      12'h0a2
`define PBW_ADDR_TIMER_A_COUNTER  12'h0a4
`define PBW_ADDR_TIMER_B_CONTROL  12'h0b0
`define PBW_ADDR_I2C_STATUS       12'h0c0
`define PBW_ADDR_SERIAL_A_STATUS  12'h0c4
`define PBW_ADDR_SERIAL_B_STATUS  12'h0c8
`define PBW_ADDR_RT_BUF_LOW       12'h0e0
`define PBW_ADDR_RT_BUF_HIGH      12'h0e1
`define PBW_ADDR_ADC_MODE         12'h0f0
`define PBW_ADDR_ADC_CHAN_SEL     12'h0f1
`define PBW_ADDR_ADC_CMP_MODE     12'h0f2
`define PBW_ADDR_ADC_CMP_THRESH   12'h0f3
`define PBW_ADDR_ADC_RESULT       12'h0f4
`define PBW_ADDR_ADC_RESULT_HIGH  12'h0f6

// ==========================================================================
// Wait control field and access timing
// ==========================================================================
`define PBW_M_MSB                 2
`define PBW_M_LSB                 0
`define PBW_BASE_CYCLES           8'h03
`define PBW_WAIT_BASE             8'h02
`define PBW_K_WDOG2               3'h3
`define PBW_K_ONE                 3'h1
`define PBW_K_WDOG1_MAX           3'h5
`define PBW_K_TIMER_WR_MAX        3'h2
`define PBW_K_ADC_MAX             3'h2
`define PBW_PERIODS_WDOG1         3'h2
`define PBW_PERIODS_TIMER_RD      3'h1
`define PBW_PERIODS_TIMER_WR      3'h5
`define PBW_PERIODS_ADC           3'h2
`define PBW_OSC_TIMEOUT           8'hc8

`endif

// [src/pbw_pkg.sv]
`default_nettype none

package pbw_pkg;

   typedef enum logic [3:0] {
      PBW_IDLE = 4'b0001,
      PBW_WAIT = 4'b0010,
      PBW_DONE = 4'b0100,
      PBW_HANG = 4'b1000
   } pbw_state_type;

   typedef enum logic [2:0] {
      PBW_ORDINARY,
      PBW_WDOG1,
      PBW_FIXED_THREE,
      PBW_FIXED_ONE,
      PBW_TIMER_RD,
      PBW_TIMER_WR,
      PBW_ADC
   } pbw_class_type;

endpackage : pbw_pkg

`default_nettype wire

// [src/pbw_wait_calc.sv]
`default_nettype none
`include "pbw_consts.svh"

module pbw_wait_calc (
   input  wire logic [2:0] i_m,
   input  wire logic [7:0] i_ratio,
   input  wire logic [2:0] i_periods,
   input  wire logic       i_plus_one,
   input  wire logic [2:0] i_k_min,
   input  wire logic [2:0] i_k_max,
   output logic      [2:0] o_k
);
   import pbw_pkg::*;

   logic [10:0] numerator;
   logic [3:0]  divisor;
   logic [10:0] quotient;
   logic [3:0]  remainder;
   logic [11:0] raw;

   always_comb begin
      numerator = 11'(i_periods) * 11'(i_ratio);
      divisor   = 4'(`PBW_WAIT_BASE) + 4'(i_m);
      quotient  = numerator / 11'(divisor);
      remainder = 4'(numerator % 11'(divisor));
      // Fraction r/(2+m) of a CPU period rounds up only above 1/(2+m)
      raw = 12'(quotient) + 12'(remainder > 4'h1) + 12'(i_plus_one);
      if (raw < 12'(i_k_min)) begin
         o_k = i_k_min;
      end else if (raw > 12'(i_k_max)) begin
         o_k = i_k_max;
      end else begin
         o_k = raw[2:0];
      end
   end

endmodule : pbw_wait_calc

`default_nettype wire

// [src/pbw_bridge.sv]
// Summary of operation
// - Stretch conflicting peripheral accesses for safe transfer
// - CPU stalls; time grows by waits exactly
// - Special registers add (2+m)*k waits
// - Special access lasts 3+m+(2+m)*k clocks
// - m comes from wait control bits 2:0
// - Plain access with no waits is three clocks
// - Watchdog one mode write: k 1..5
// - Watchdog two mode write: k fixed 3
// - Timer A capture/counter reads: k = 1
// - Timer A compare writes: k 0..2, back-to-back only
// - Timer B control read-modify-write: k 1 on write
// - I2C and serial status reads: k fixed 1
// - Real-time buffer writes: k 1 when output disabled
// - ADC control writes, result reads: k 1..2
// - Fraction rounds down when at most 1/(2+m)
// - Computed waits are an upper bound
// - No main clock: special access hangs until reset
`default_nettype none
`include "pbw_consts.svh"

module pbw_bridge (
   input  wire logic        i_clock,
   input  wire logic        i_reset,
   input  wire logic        i_cpu_req,
   input  wire logic        i_cpu_write,
   input  wire logic        i_cpu_rmw,
   input  wire logic [11:0] i_cpu_addr,
   input  wire logic [15:0] i_cpu_wdata,
   output logic             o_cpu_wait,
   output logic             o_cpu_done,
   output logic      [15:0] o_cpu_rdata,
   input  wire logic [7:0]  i_wait_control,
   input  wire logic        i_rt_output_enable_bit,
   input  wire logic [7:0]  i_cpu_per_main,
   input  wire logic        i_main_oscillator_input,
   output logic             o_per_req,
   output logic             o_per_write,
   output logic      [11:0] o_per_addr,
   output logic      [15:0] o_per_wdata,
   input  wire logic [15:0] i_per_rdata
);
   import pbw_pkg::*;

   // =======================================================================
   // Main oscillator presence
   // =======================================================================
   logic       osc_meta;
   logic       osc_sync;
   logic       osc_prev;
   logic [7:0] osc_idle;
   logic       osc_alive;

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         osc_meta <= 1'b0;
         osc_sync <= 1'b0;
         osc_prev <= 1'b0;
      end else begin
         osc_meta <= i_main_oscillator_input;
         osc_sync <= osc_meta;
         osc_prev <= osc_sync;
      end
   end

   // Starts as dead: no special access may pass before an edge is seen
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         osc_idle <= `PBW_OSC_TIMEOUT;
      end else if (osc_sync != osc_prev) begin
         osc_idle <= 8'h00;
      end else if (osc_idle != `PBW_OSC_TIMEOUT) begin
         osc_idle <= osc_idle + 8'h01;
      end
   end

   assign osc_alive = (osc_idle != `PBW_OSC_TIMEOUT);

   // =======================================================================
   // Register classification
   // =======================================================================
   pbw_state_type state;
   pbw_state_type next_state;
   pbw_class_type req_class;
   logic          accept;
   logic [2:0]    m;
   logic [11:0]   last_cc_addr;
   logic          last_cc_write;
   logic          is_cc;

   assign accept = (state == PBW_IDLE) && i_cpu_req;
   assign m      = i_wait_control[`PBW_M_MSB:`PBW_M_LSB];
   assign is_cc  = (i_cpu_addr == `PBW_ADDR_TIMER_A_CC0) ||
                   (i_cpu_addr == `PBW_ADDR_TIMER_A_CC1);

   always_comb begin
      req_class = PBW_ORDINARY;
      unique case (i_cpu_addr)
         `PBW_ADDR_WDOG1_MODE:
            if (i_cpu_write) req_class = PBW_WDOG1;
         `PBW_ADDR_WDOG2_MODE:
            if (i_cpu_write) req_class = PBW_FIXED_THREE;
         `PBW_ADDR_TIMER_A_CC0, `PBW_ADDR_TIMER_A_CC1: begin
            if (!i_cpu_write) begin
               req_class = PBW_TIMER_RD;
            end else if (last_cc_write && last_cc_addr == i_cpu_addr) begin
               req_class = PBW_TIMER_WR;
            end
         end
         `PBW_ADDR_TIMER_A_COUNTER:
            if (!i_cpu_write) req_class = PBW_TIMER_RD;
         `PBW_ADDR_TIMER_B_CONTROL:
            if (i_cpu_write && i_cpu_rmw) req_class = PBW_FIXED_ONE;
         `PBW_ADDR_I2C_STATUS, `PBW_ADDR_SERIAL_A_STATUS, `PBW_ADDR_SERIAL_B_STATUS:
            if (!i_cpu_write) req_class = PBW_FIXED_ONE;
         `PBW_ADDR_RT_BUF_LOW, `PBW_ADDR_RT_BUF_HIGH:
            if (i_cpu_write && !i_rt_output_enable_bit) req_class = PBW_FIXED_ONE;
         `PBW_ADDR_ADC_MODE, `PBW_ADDR_ADC_CHAN_SEL,
         `PBW_ADDR_ADC_CMP_MODE, `PBW_ADDR_ADC_CMP_THRESH:
            if (i_cpu_write) req_class = PBW_ADC;
         `PBW_ADDR_ADC_RESULT, `PBW_ADDR_ADC_RESULT_HIGH:
            if (!i_cpu_write) req_class = PBW_ADC;
         default: req_class = PBW_ORDINARY;
      endcase
   end

   // Only the immediately preceding access counts as back to back
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         last_cc_write <= 1'b0;
         last_cc_addr  <= 12'h000;
      end else if (accept) begin
         last_cc_write <= i_cpu_write && is_cc;
         last_cc_addr  <= i_cpu_addr;
      end
   end

   // =======================================================================
   // Wait factor and access length
   // =======================================================================
   logic [2:0] periods;
   logic       plus_one;
   logic [2:0] k_min;
   logic [2:0] k_max;
   logic [2:0] k_calc;
   logic [2:0] k_sel;
   logic [7:0] next_total;
   logic [7:0] total;

   always_comb begin
      periods  = `PBW_PERIODS_ADC;
      plus_one = 1'b1;
      k_min    = `PBW_K_ONE;
      k_max    = `PBW_K_ADC_MAX;
      unique case (req_class)
         PBW_WDOG1: begin
            periods = `PBW_PERIODS_WDOG1;
            k_max   = `PBW_K_WDOG1_MAX;
         end
         PBW_TIMER_RD: begin
            periods = `PBW_PERIODS_TIMER_RD;
            k_max   = `PBW_K_ONE;
         end
         PBW_TIMER_WR: begin
            periods  = `PBW_PERIODS_TIMER_WR;
            plus_one = 1'b0;
            k_min    = 3'h0;
            k_max    = `PBW_K_TIMER_WR_MAX;
         end
         default: begin
            periods = `PBW_PERIODS_ADC;
         end
      endcase
   end

   pbw_wait_calc u_calc (
      .i_m        (m),
      .i_ratio    (i_cpu_per_main),
      .i_periods  (periods),
      .i_plus_one (plus_one),
      .i_k_min    (k_min),
      .i_k_max    (k_max),
      .o_k        (k_calc)
   );

   always_comb begin
      unique case (req_class)
         PBW_ORDINARY:    k_sel = 3'h0;
         PBW_FIXED_THREE: k_sel = `PBW_K_WDOG2;
         PBW_FIXED_ONE:   k_sel = `PBW_K_ONE;
         default:         k_sel = k_calc;
      endcase
      // Upper bound; instruction fetch effects can only shorten it upstream
      next_total = `PBW_BASE_CYCLES + 8'(m) +
                   (`PBW_WAIT_BASE + 8'(m)) * 8'(k_sel);
   end

   // =======================================================================
   // Access sequencer
   // =======================================================================
   logic [7:0] remain;
   logic       special;

   assign special = (k_sel != 3'h0);

   always_comb begin
      next_state = state;
      unique case (state)
         PBW_IDLE:
            if (accept) begin
               // A stalled peripheral clock can never resolve the conflict
               next_state = (special && !osc_alive) ? PBW_HANG : PBW_WAIT;
            end
         PBW_WAIT:
            if (remain == 8'h01) next_state = PBW_DONE;
         PBW_DONE:
            next_state = PBW_IDLE;
         PBW_HANG:
            next_state = PBW_HANG;
         default:
            next_state = PBW_IDLE;
      endcase
   end

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         state <= PBW_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         remain <= 8'h00;
         total  <= 8'h00;
      end else if (accept) begin
         remain <= next_total - 8'h02;
         total  <= next_total;
      end else if (state == PBW_WAIT) begin
         remain <= remain - 8'h01;
      end
   end

   // Request side stays frozen from accept until the access ends
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         o_per_write <= 1'b0;
         o_per_addr  <= 12'h000;
         o_per_wdata <= 16'h0000;
      end else if (accept) begin
         o_per_write <= i_cpu_write;
         o_per_addr  <= i_cpu_addr;
         o_per_wdata <= i_cpu_wdata;
      end
   end

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         o_cpu_rdata <= 16'h0000;
      end else if (state == PBW_WAIT && remain == 8'h01) begin
         o_cpu_rdata <= o_per_write ? 16'h0000 : i_per_rdata;
      end
   end

   assign o_per_req  = (state != PBW_IDLE);
   assign o_cpu_done = (state == PBW_DONE);
   assign o_cpu_wait = accept || (state == PBW_WAIT) || (state == PBW_HANG);

   // =======================================================================
   // Checks
   // =======================================================================
   logic [7:0] cycles;

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         cycles <= 8'h00;
      end else if (accept) begin
         cycles <= 8'h01;
      end else if (state != PBW_IDLE && cycles != 8'hff) begin
         cycles <= cycles + 8'h01;
      end
   end

   sequence s_taken;
      accept;
   endsequence

   sequence s_finish;
      o_cpu_done ##1 (state == PBW_IDLE);
   endsequence

   property p_length;
      @(posedge i_clock) disable iff (i_reset)
         o_cpu_done |-> (cycles + 8'h01 == total);
   endproperty
   a_length: assert property (p_length) else $error("access length wrong");

   property p_ordinary;
      @(posedge i_clock) disable iff (i_reset)
         (accept && req_class == PBW_ORDINARY) |=>
            (total == `PBW_BASE_CYCLES + 8'($past(i_wait_control[2:0])));
   endproperty
   a_ordinary: assert property (p_ordinary) else $error("ordinary length wrong");

   property p_base;
      @(posedge i_clock) disable iff (i_reset)
         (s_taken and (req_class == PBW_ORDINARY && m == 3'h0)) |=> ##1 s_finish;
   endproperty
   a_base: assert property (p_base) else $error("base access not three clocks");

   property p_stall;
      @(posedge i_clock) disable iff (i_reset)
         (state == PBW_WAIT) |-> o_cpu_wait && !o_cpu_done;
   endproperty
   a_stall: assert property (p_stall) else $error("cpu not stalled");

   property p_hold;
      @(posedge i_clock) disable iff (i_reset)
         (state == PBW_WAIT) |=>
            o_per_req && $stable(o_per_addr) && $stable(o_per_wdata) && $stable(o_per_write);
   endproperty
   a_hold: assert property (p_hold) else $error("peripheral request moved");

   property p_rdata;
      @(posedge i_clock) disable iff (i_reset)
         (o_cpu_done && !o_per_write) |-> (o_cpu_rdata == $past(i_per_rdata));
   endproperty
   a_rdata: assert property (p_rdata) else $error("read data not from final cycle");

   property p_wdog2;
      @(posedge i_clock) disable iff (i_reset)
         (accept && i_cpu_write && i_cpu_addr == `PBW_ADDR_WDOG2_MODE) |-> (k_sel == 3'h3);
   endproperty
   a_wdog2: assert property (p_wdog2) else $error("watchdog two factor wrong");

   property p_wdog1;
      @(posedge i_clock) disable iff (i_reset)
         (accept && req_class == PBW_WDOG1) |-> (k_sel >= 3'h1 && k_sel <= 3'h5);
   endproperty
   a_wdog1: assert property (p_wdog1) else $error("watchdog one factor out of range");

   property p_status;
      @(posedge i_clock) disable iff (i_reset)
         (accept && !i_cpu_write && i_cpu_addr == `PBW_ADDR_I2C_STATUS) |-> (k_sel == 3'h1);
   endproperty
   a_status: assert property (p_status) else $error("status read factor wrong");

   property p_hang;
      @(posedge i_clock) disable iff (i_reset)
         (state == PBW_HANG) |=> (state == PBW_HANG) && o_cpu_wait [*3];
   endproperty
   a_hang: assert property (p_hang) else $error("hung access released");

endmodule : pbw_bridge

`default_nettype wire

// [bench/pbw_periph_model.sv]
`default_nettype none

module pbw_periph_model (
   input  wire logic        i_clock,
   input  wire logic        i_osc_enable,
   input  wire logic        i_per_req,
   input  wire logic        i_per_write,
   input  wire logic [11:0] i_per_addr,
   input  wire logic [15:0] i_per_wdata,
   output logic      [15:0] o_per_rdata,
   output logic             o_main_osc
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [15:0] mem [0:4095];
   logic [15:0] idle_pat = 16'h5a5a;

   // ==========================================================
   // Main oscillator: free phase, frozen when the source is off
   // ==========================================================
   initial begin
      o_main_osc = 1'b0;
      for (int i = 0; i < 4096; i++) begin
         mem[i] = {4'hc, i[11:0]};
      end
      forever begin
         #137;
         if (i_osc_enable) begin
            o_main_osc = ~o_main_osc;
         end
      end
   end

   // ==========================================================
   // Register store; unselected data bus shows a moving pattern
   // ==========================================================
   always @(posedge i_clock) begin
      idle_pat <= idle_pat + 16'h0101;
      if (i_per_req && i_per_write) begin
         mem[i_per_addr] <= i_per_wdata;
      end
   end

   always @* begin
      if (i_per_req && !i_per_write) begin
         o_per_rdata = mem[i_per_addr];
      end else begin
         o_per_rdata = ~idle_pat;
      end
   end
endmodule : pbw_periph_model

`default_nettype wire

// [bench/pbw_bridge_test.sv]
`default_nettype none
`include "pbw_consts.svh"

module pbw_bridge_test;
   timeunit 1ns;
   timeprecision 1ns;

   logic        clock, reset, cpu_req, cpu_write, cpu_rmw, rt_en, osc_en;
   logic [11:0] cpu_addr, per_addr;
   logic [15:0] cpu_wdata, cpu_rdata, per_wdata, per_rdata;
   logic [7:0]  wait_control, cpu_per_main;
   logic        cpu_wait, cpu_done, per_req, per_write, main_osc;
   int          errors, total_checks, cycles, m, ratio;

   pbw_bridge dut (
      .i_clock(clock), .i_reset(reset), .i_cpu_req(cpu_req), .i_cpu_write(cpu_write),
      .i_cpu_rmw(cpu_rmw), .i_cpu_addr(cpu_addr), .i_cpu_wdata(cpu_wdata),
      .o_cpu_wait(cpu_wait), .o_cpu_done(cpu_done), .o_cpu_rdata(cpu_rdata),
      .i_wait_control(wait_control), .i_rt_output_enable_bit(rt_en),
      .i_cpu_per_main(cpu_per_main), .i_main_oscillator_input(main_osc),
      .o_per_req(per_req), .o_per_write(per_write), .o_per_addr(per_addr),
      .o_per_wdata(per_wdata), .i_per_rdata(per_rdata));

   pbw_periph_model periph (
      .i_clock(clock), .i_osc_enable(osc_en), .i_per_req(per_req),
      .i_per_write(per_write), .i_per_addr(per_addr), .i_per_wdata(per_wdata),
      .o_per_rdata(per_rdata), .o_main_osc(main_osc));

   always #50 clock = ~clock;

   // ==========================================================
   // Checking and closing
   // ==========================================================
   task automatic results();
      if (errors == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : results

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // Whole run needs under 15000 cycles
   always @(posedge clock) begin
      cycles++;
      if (cycles == 40000) begin
         errors++;
         results();
      end
   end

   // Expected access length from the wait formula, worked out independently
   function automatic int total(input int per, input int plus, input int kmin, input int kmax);
      int n, k;
      n = per * ratio;
      k = n / (2 + m) + (((n % (2 + m)) > 1) ? 1 : 0) + plus;
      if (k < kmin) k = kmin;
      if (k > kmax) k = kmax;
      return 3 + m + (2 + m) * k;
   endfunction : total

   task automatic setup(input int mv, input int rv);
      m = mv;
      ratio = rv;
      @(posedge clock);
      wait_control <= {5'b10101, mv[2:0]};
      cpu_per_main <= rv[7:0];
      @(negedge clock);
   endtask : setup

   task automatic do_reset();
      @(posedge clock);
      reset <= 1'b1;
      repeat (8) @(posedge clock);
      reset <= 1'b0;
      // Oscillator must be seen alive before special accesses
      repeat (10) @(posedge clock);
   endtask : do_reset

   // Request held until done; wait judged every cycle, hold and write data from the second, read data at the end
   task automatic access(input logic [11:0] a, input logic w, input logic r,
                         input logic [15:0] d, input int tot, input logic [15:0] rd);
      int n;
      n = 0;
      @(posedge clock);
      cpu_req   <= 1'b1;
      cpu_write <= w;
      cpu_rmw   <= r;
      cpu_addr  <= a;
      cpu_wdata <= d;
      do begin
         @(negedge clock);
         n++;
         check(cpu_wait, n < tot);
         if (n >= 2) begin
            check({per_req, per_write, per_addr}, {1'b1, w, a});
            if (w) check(per_wdata, d);
         end
      end while (cpu_done !== 1'b1 && n < 80);
      check(n, tot);
      check(cpu_rdata, w ? 16'h0000 : rd);
      @(posedge clock);
      cpu_req <= 1'b0;
   endtask : access

   // ==========================================================
   // Scenarios
   // ==========================================================
   task automatic t_ordinary();
      for (int i = 0; i < 8; i++) begin
         setup(i, 3);
         access(12'h010, 1'b0, 1'b0, 16'h0, total(0, 0, 0, 0), 16'hc010);
         access(12'h020, 1'b1, 1'b0, 16'hbe00 + i, 3 + i, 16'h0);
         access(12'h020, 1'b0, 1'b0, 16'h0, 3 + i, 16'hbe00 + i);
      end
   endtask : t_ordinary

   task automatic t_fixed();
      logic [11:0] a [8] = '{`PBW_ADDR_WDOG2_MODE, `PBW_ADDR_I2C_STATUS,
         `PBW_ADDR_SERIAL_A_STATUS, `PBW_ADDR_SERIAL_B_STATUS, `PBW_ADDR_TIMER_B_CONTROL,
         `PBW_ADDR_TIMER_B_CONTROL, `PBW_ADDR_RT_BUF_LOW, `PBW_ADDR_RT_BUF_HIGH};
      logic       w [8] = '{1, 0, 0, 0, 1, 1, 1, 1};
      logic       r [8] = '{0, 0, 0, 0, 1, 0, 0, 0};
      int         k [8] = '{3, 1, 1, 1, 1, 0, 1, 1};
      setup(1, 2);
      for (int e = 0; e < 2; e++) begin
         @(posedge clock);
         rt_en <= e[0];
         for (int i = 0; i < 8; i++) begin
            access(a[i], w[i], r[i], 16'h1234, total(0, 0, (i > 5 && e == 1) ? 0 : k[i],
                   (i > 5 && e == 1) ? 0 : k[i]), {4'hc, a[i]});
         end
      end
   endtask : t_fixed

   task automatic t_calc();
      logic [11:0] a [10] = '{`PBW_ADDR_WDOG1_MODE, `PBW_ADDR_TIMER_A_CC0,
         `PBW_ADDR_TIMER_A_CC1, `PBW_ADDR_TIMER_A_COUNTER, `PBW_ADDR_ADC_MODE,
         `PBW_ADDR_ADC_CHAN_SEL, `PBW_ADDR_ADC_CMP_MODE, `PBW_ADDR_ADC_CMP_THRESH,
         `PBW_ADDR_ADC_RESULT, `PBW_ADDR_ADC_RESULT_HIGH};
      logic w [10] = '{1, 0, 0, 0, 1, 1, 1, 1, 0, 0};
      int   p [10] = '{2, 1, 1, 1, 2, 2, 2, 2, 2, 2};
      int   h [10] = '{5, 1, 1, 1, 2, 2, 2, 2, 2, 2};
      int   rv [6] = '{1, 2, 3, 4, 7, 11};
      int   mv [3] = '{0, 1, 7};
      for (int j = 0; j < 3; j++) begin
         for (int q = 0; q < 6; q++) begin
            setup(mv[j], rv[q]);
            for (int i = 0; i < 10; i++) begin
               access(a[i], w[i], 1'b0, 16'h0, total(p[i], 1, 1, h[i]),
                      {4'hc, a[i]});
            end
         end
      end
   endtask : t_calc

   task automatic t_timer_write();
      for (int j = 0; j < 2; j++) begin
         setup(j * 7, 1);
         access(12'h010, 1'b0, 1'b0, 16'h0, 3 + m, 16'hc010);
         access(`PBW_ADDR_TIMER_A_CC0, 1'b1, 1'b0, 16'h0a01, 3 + m, 16'h0);
         access(`PBW_ADDR_TIMER_A_CC0, 1'b1, 1'b0, 16'h0a02, total(5, 0, 0, 2), 16'h0);
         access(`PBW_ADDR_TIMER_A_CC1, 1'b1, 1'b0, 16'h0b01, 3 + m, 16'h0);
         access(`PBW_ADDR_TIMER_A_CC1, 1'b1, 1'b0, 16'h0b02, total(5, 0, 0, 2), 16'h0);
         access(`PBW_ADDR_TIMER_A_CC1, 1'b0, 1'b0, 16'h0, total(1, 1, 1, 1), 16'h0b02);
         access(`PBW_ADDR_TIMER_A_CC1, 1'b1, 1'b0, 16'h0b03, 3 + m, 16'h0);
      end
   endtask : t_timer_write

   task automatic t_hang();
      setup(0, 2);
      @(posedge clock);
      osc_en <= 1'b0;
      repeat (260) @(posedge clock);
      access(12'h010, 1'b0, 1'b0, 16'h0, 3, 16'hc010);
      @(posedge clock);
      cpu_req   <= 1'b1;
      cpu_write <= 1'b0;
      cpu_addr  <= `PBW_ADDR_I2C_STATUS;
      repeat (100) begin
         @(negedge clock);
         check({cpu_wait, cpu_done}, 2'b10);
      end
      @(posedge clock);
      cpu_req <= 1'b0;
      osc_en  <= 1'b1;
      do_reset();
      access(`PBW_ADDR_I2C_STATUS, 1'b0, 1'b0, 16'h0, total(0, 0, 1, 1), 16'hc0c0);
   endtask : t_hang

   initial begin
      clock = 1'b0;
      reset = 1'b1;
      {cpu_req, cpu_write, cpu_rmw, rt_en} = 4'h0;
      osc_en       = 1'b1;
      cpu_addr     = 12'h000;
      cpu_wdata    = 16'h0000;
      wait_control = 8'h00;
      cpu_per_main = 8'h02;
      {errors, total_checks, cycles, m, ratio} = {32'd0, 32'd0, 32'd0, 32'd0, 32'd2};
      repeat (8) @(posedge clock);
      reset <= 1'b0;
      repeat (10) @(posedge clock);
      t_ordinary();
      t_fixed();
      t_calc();
      t_timer_write();
      t_hang();
      results();
   end
endmodule : pbw_bridge_test

`default_nettype wire
